// ### design/cpu_bitops_pkg.sv
// Package: constants, opcodes and command layout for the bit and data-move execution unit
package cpu_bitops_pkg;
   // ==========================================
   // Register map (byte addresses)
   localparam logic [7:0] ADDR_CMD  = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam logic [7:0] ADDR_GPR  = 8'h08;
   localparam logic [7:0] ADDR_MEM  = 8'h0c;
   localparam logic [7:0] ADDR_IO   = 8'h10;
   localparam logic [7:0] ADDR_SP   = 8'h14;
   // ==========================================
   // Field positions
   localparam int STAT_BUSY_BIT = 8;
   localparam int SEL_LSB       = 8;
   localparam int SEL_WRITE_BIT = 31;
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;
   localparam int FLAG_I = 7;
   localparam int PTR_REG = 30;
   // ==========================================
   // Reset values
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] SP_RESET     = 8'hff;
   localparam logic [7:0] GPR_RESET    = 8'h00;
   // ==========================================
   // Cycle counts
   localparam logic [1:0] CYC_SINGLE     = 2'h1;
   localparam logic [1:0] CYC_PUSH       = 2'h1;
   localparam logic [1:0] CYC_POP        = 2'h2;
   localparam logic [1:0] CYC_ATOMIC     = 2'h2;
   localparam logic [1:0] CYC_SRAM_EXTRA = 2'h1;
   // ==========================================
   // Bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [4:0] {
      OP_NOP, OP_IO_READ, OP_IO_WRITE, OP_PUSH, OP_POP,
      OP_SWAP_MEMORY_BYTE, OP_LOAD_SET_MEMORY, OP_LOAD_CLEAR_MEMORY, OP_LOAD_TOGGLE_MEMORY,
      OP_ROTATE_LEFT_THROUGH_CARRY, OP_ROTATE_RIGHT_THROUGH_CARRY,
      OP_IO_BIT_SET, OP_IO_BIT_CLEAR, OP_BIT_TO_TRANSFER_FLAG, OP_TRANSFER_FLAG_TO_BIT,
      OP_FLAG_SET, OP_FLAG_CLEAR
   } op_t;

   // Command word: op [20:16], register [15:11], bit/flag [10:8], I/O address [7:0]
   typedef struct packed {
      op_t        op;
      logic [4:0] regIdx;
      logic [2:0] bitSel;
      logic [7:0] addr;
   } cmd_t;

   typedef enum {ST_IDLE, ST_EXEC} state_t;
endpackage : cpu_bitops_pkg

// ### design/cpu_bitops_exec.sv
// Execution unit for I/O moves, stack, atomic memory, rotate, bit and flag operations
// How it works
// - I/O read copies location, flags untouched, 1 cycle
// - Push stores register, 1 cycle plus memory
// - Pop loads register, 2 cycles plus memory
// - Load-set returns old byte, stores OR
// - Load-clear returns old byte, stores AND-NOT
// - Load-toggle returns old byte, stores XOR
// - Rotate left through carry, Z C N V H
// - Rotate right through carry, Z C N V
// - I/O bit-set forces bit high, 1 cycle
// - I/O bit-clear forces bit low, 1 cycle
// - Bit-store copies bit into transfer flag only
// - Bit-load copies transfer flag into bit
// - Overflow flag set/clear, one cycle, alone
// - Half-carry flag set/clear, one cycle, alone
// - Signed flag set/clear, one cycle, alone
// - Counts hold for internal memory only
// - Internal SRAM access adds one cycle
`timescale 1ns/1ps
module cpu_bitops_exec #(
   parameter int MEM_AW = 8,
   parameter int IO_AW  = 5
) (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   // AXI4-Lite write channels
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read channels
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Status
   output logic             busy,
   output logic             opDone
);
   import cpu_bitops_pkg::*;

   // ==========================================
   // Storage
   logic [7:0]        gprReg [32];
   logic [7:0]        memReg [2**MEM_AW];
   logic [7:0]        ioReg  [2**IO_AW];
   logic [7:0]        statusReg, statusNext;
   logic [MEM_AW-1:0] spReg, spNext;
   cmd_t              cmdReg;
   state_t            stateReg;
   logic [1:0]        cntReg;
   logic [4:0]        gprSelReg;
   logic [MEM_AW-1:0] memSelReg;
   logic [IO_AW-1:0]  ioSelReg;

   // Bus channel state
   logic [7:0]  awAddrReg;
   logic [31:0] wDataReg;
   logic        awHeldReg, wHeldReg, bValidReg, rValidReg;
   logic [1:0]  bRespReg, rRespReg;
   logic [31:0] rDataReg;

   function automatic logic addrHit(input logic [7:0] a);
      return a == ADDR_CMD || a == ADDR_STAT || a == ADDR_GPR ||
             a == ADDR_MEM || a == ADDR_IO || a == ADDR_SP;
   endfunction : addrHit
   // Total cycles less one; memory operations pay the internal SRAM cycle
   function automatic logic [1:0] cyclesLess1(input op_t op);
      case (op)
         OP_PUSH: return CYC_PUSH + CYC_SRAM_EXTRA - 2'h1;
         OP_POP: return CYC_POP + CYC_SRAM_EXTRA - 2'h1;
         OP_SWAP_MEMORY_BYTE, OP_LOAD_SET_MEMORY,
         OP_LOAD_CLEAR_MEMORY, OP_LOAD_TOGGLE_MEMORY:
            return CYC_ATOMIC + CYC_SRAM_EXTRA - 2'h1;
         default: return CYC_SINGLE - 2'h1;
      endcase
   endfunction : cyclesLess1
   // ==========================================
   // Bus slave
   logic       wrFire, wrOk, rdFire, finish, strbFull;
   logic [7:0] wrAddr;
   logic [3:0] wStrbReg;
   assign wrAddr   = awAddrReg;
   assign wrFire   = awHeldReg && wHeldReg && !bValidReg;
   assign strbFull = (wStrbReg == 4'hf);
   // Partial writes and writes while an operation runs are refused
   assign wrOk     = wrFire && addrHit(wrAddr) && strbFull && !busy;
   assign s_axi_awready = !awHeldReg;
   assign s_axi_wready  = !wHeldReg;
   assign s_axi_bvalid  = bValidReg;
   assign s_axi_bresp   = bRespReg;
   assign s_axi_arready = !rValidReg;
   assign s_axi_rvalid  = rValidReg;
   assign s_axi_rdata   = rDataReg;
   assign s_axi_rresp   = rRespReg;
   assign rdFire = s_axi_arvalid && !rValidReg;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         awHeldReg <= 1'b0;
         wHeldReg  <= 1'b0;
         awAddrReg <= 8'h00;
         wDataReg  <= 32'h0000_0000;
         wStrbReg  <= 4'h0;
         bValidReg <= 1'b0;
         bRespReg  <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !awHeldReg) begin
            awHeldReg <= 1'b1;
            awAddrReg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !wHeldReg) begin
            wHeldReg <= 1'b1;
            wDataReg <= s_axi_wdata;
            wStrbReg <= s_axi_wstrb;
         end
         if (wrFire) begin
            awHeldReg <= 1'b0;
            wHeldReg  <= 1'b0;
            bValidReg <= 1'b1;
            bRespReg  <= wrOk ? RESP_OKAY : RESP_SLVERR;
         end else if (bValidReg && s_axi_bready) begin
            bValidReg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rValidReg <= 1'b0;
         rDataReg  <= 32'h0000_0000;
         rRespReg  <= RESP_OKAY;
      end else if (rdFire) begin
         rValidReg <= 1'b1;
         rRespReg  <= addrHit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         case (s_axi_araddr)
            ADDR_CMD:  rDataReg <= 32'(cmdReg);
            ADDR_STAT: rDataReg <= 32'({busy, statusReg});
            ADDR_GPR:  rDataReg <= 32'({gprSelReg, gprReg[gprSelReg]});
            ADDR_MEM:  rDataReg <= 32'({memSelReg, memReg[memSelReg]});
            ADDR_IO:   rDataReg <= 32'({ioSelReg, ioReg[ioSelReg]});
            ADDR_SP:   rDataReg <= 32'(spReg);
            default:   rDataReg <= 32'h0000_0000;
         endcase
      end else if (rValidReg && s_axi_rready) begin
         rValidReg <= 1'b0;
      end
   end

   // ==========================================
   // Sequencer: effects commit together on the last cycle of an operation
   assign busy   = (stateReg == ST_EXEC);
   assign finish = busy && cntReg == 2'h0;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stateReg <= ST_IDLE;
         cntReg   <= 2'h0;
         cmdReg   <= '0;
         opDone   <= 1'b0;
      end else begin
         opDone <= finish;
         case (stateReg)
            ST_IDLE: if (wrOk && wrAddr == ADDR_CMD) begin
               cmdReg   <= cmd_t'(wDataReg[20:0]);
               cntReg   <= cyclesLess1(op_t'(wDataReg[20:16]));
               stateReg <= ST_EXEC;
            end
            ST_EXEC: if (cntReg == 2'h0) begin
               stateReg <= ST_IDLE;
            end else begin
               cntReg <= cntReg - 2'h1;
            end
            default: stateReg <= ST_IDLE;
         endcase
      end
   end

   // ==========================================
   // Datapath
   logic gprWe, memWe, ioWe;
   logic [4:0] gprWa;
   logic [MEM_AW-1:0] memWa;
   logic [IO_AW-1:0] ioWa;
   logic [7:0] gprWd, memWd, ioWd, opnd, memOld, ioOld, rot;
   logic [MEM_AW-1:0] zAddr;

   assign opnd   = gprReg[cmdReg.regIdx];
   assign zAddr  = gprReg[PTR_REG][MEM_AW-1:0];
   assign memOld = memReg[zAddr];
   assign ioOld  = ioReg[cmdReg.addr[IO_AW-1:0]];
   always_comb begin
      gprWe = 1'b0;
      gprWa = cmdReg.regIdx;
      gprWd = 8'h00;
      memWe = 1'b0;
      memWa = zAddr;
      memWd = 8'h00;
      ioWe  = 1'b0;
      ioWa  = cmdReg.addr[IO_AW-1:0];
      ioWd  = ioOld;
      rot   = 8'h00;
      statusNext = statusReg;
      spNext   = spReg;
      if (finish) begin
         case (cmdReg.op)
            OP_IO_READ: begin
               gprWe = 1'b1;
               gprWd = ioOld;
            end
            OP_IO_WRITE: begin
               ioWe = 1'b1;
               ioWd = opnd;
            end
            OP_PUSH: begin
               memWe  = 1'b1;
               memWa  = spReg;
               memWd  = opnd;
               spNext = spReg - MEM_AW'(1);
            end
            OP_POP: begin
               spNext = spReg + MEM_AW'(1);
               gprWe  = 1'b1;
               gprWd  = memReg[spNext];
            end
            OP_SWAP_MEMORY_BYTE, OP_LOAD_SET_MEMORY, OP_LOAD_CLEAR_MEMORY, OP_LOAD_TOGGLE_MEMORY: begin
               gprWe = 1'b1;
               gprWd = memOld;
               memWe = 1'b1;
               case (cmdReg.op)
                  OP_LOAD_SET_MEMORY:    memWd = opnd | memOld;
                  OP_LOAD_CLEAR_MEMORY:  memWd = ~opnd & memOld;
                  OP_LOAD_TOGGLE_MEMORY: memWd = opnd ^ memOld;
                  default:               memWd = opnd;
               endcase
            end
            OP_ROTATE_LEFT_THROUGH_CARRY: begin
               rot   = {opnd[6:0], statusReg[FLAG_C]};
               gprWe = 1'b1;
               gprWd = rot;
               statusNext[FLAG_C] = opnd[7];
               statusNext[FLAG_Z] = (rot == 8'h00);
               statusNext[FLAG_N] = rot[7];
               statusNext[FLAG_V] = rot[7] ^ opnd[7];
               statusNext[FLAG_H] = opnd[3];
            end
            OP_ROTATE_RIGHT_THROUGH_CARRY: begin
               rot   = {statusReg[FLAG_C], opnd[7:1]};
               gprWe = 1'b1;
               gprWd = rot;
               statusNext[FLAG_C] = opnd[0];
               statusNext[FLAG_Z] = (rot == 8'h00);
               statusNext[FLAG_N] = rot[7];
               statusNext[FLAG_V] = rot[7] ^ opnd[0];
            end
            OP_IO_BIT_SET: begin
               ioWe = 1'b1;
               ioWd[cmdReg.bitSel] = 1'b1;
            end
            OP_IO_BIT_CLEAR: begin
               ioWe = 1'b1;
               ioWd[cmdReg.bitSel] = 1'b0;
            end
            OP_BIT_TO_TRANSFER_FLAG: statusNext[FLAG_T] = opnd[cmdReg.bitSel];
            OP_TRANSFER_FLAG_TO_BIT: begin
               gprWe = 1'b1;
               gprWd = opnd;
               gprWd[cmdReg.bitSel] = statusReg[FLAG_T];
            end
            // Bit field selects the flag: C Z N V S H T I
            OP_FLAG_SET:   statusNext[cmdReg.bitSel] = 1'b1;
            OP_FLAG_CLEAR: statusNext[cmdReg.bitSel] = 1'b0;
            default: ;
         endcase
      end else if (wrOk && wDataReg[SEL_WRITE_BIT]) begin
         // Software access only while idle, so never collides with a commit
         gprWe = (wrAddr == ADDR_GPR);
         gprWa = wDataReg[SEL_LSB +: 5];
         gprWd = wDataReg[7:0];
         memWe = (wrAddr == ADDR_MEM);
         memWa = wDataReg[SEL_LSB +: MEM_AW];
         memWd = wDataReg[7:0];
         ioWe  = (wrAddr == ADDR_IO);
         ioWa  = wDataReg[SEL_LSB +: IO_AW];
         ioWd  = wDataReg[7:0];
      end
      if (wrOk && wrAddr == ADDR_STAT) statusNext = wDataReg[7:0];
      if (wrOk && wrAddr == ADDR_SP) spNext = wDataReg[MEM_AW-1:0];
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         statusReg <= STATUS_RESET;
         spReg     <= SP_RESET[MEM_AW-1:0];
         gprSelReg <= 5'h00;
         memSelReg <= '0;
         ioSelReg  <= '0;
      end else begin
         statusReg <= statusNext;
         spReg   <= spNext;
         if (wrOk && wrAddr == ADDR_GPR) gprSelReg <= wDataReg[SEL_LSB +: 5];
         if (wrOk && wrAddr == ADDR_MEM) memSelReg <= wDataReg[SEL_LSB +: MEM_AW];
         if (wrOk && wrAddr == ADDR_IO) ioSelReg <= wDataReg[SEL_LSB +: IO_AW];
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 32; i++) begin
            gprReg[i] <= GPR_RESET;
         end
      end else if (gprWe) begin
         gprReg[gprWa] <= gprWd;
      end
   end
   // Internal SRAM only; no external RAM path, so the fixed counts always hold
   always_ff @(posedge clk_sys) begin
      if (memWe) begin
         memReg[memWa] <= memWd;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (ioWe) begin
         ioReg[ioWa] <= ioWd;
      end
   end
endmodule : cpu_bitops_exec

// ### test/cpu_bitops_exec_checker.sv
// Checker: bus handshake and execution timing assertions
`timescale 1ns/1ps
module cpu_bitops_exec_checker
   import cpu_bitops_pkg::*;
(
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        rst_n,
   // Write channels
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   // Read channels
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Status
   input wire logic        busy,
   input wire logic        opDone
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // ==========================================
   // Sequences
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_op_start;
      $rose(busy);
   endsequence
   sequence s_op_end;
      $fell(busy);
   endsequence
   // ==========================================
   // Properties
   property p_wr_resp;
      s_wr_taken |-> ##2 s_axi_bvalid;
   endproperty
   property p_start_with_resp;
      s_op_start |-> s_axi_bvalid;
   endproperty
   property p_busy_bound;
      s_op_start |-> ##[1:3] s_op_end;
   endproperty
   property p_done_after_busy;
      s_op_end |-> opDone;
   endproperty
   property p_done_pulse;
      opDone |=> !opDone;
   endproperty
   property p_b_stands;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   property p_r_stands;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   property p_rd_resp;
      s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid;
   endproperty
   property p_unmapped;
      s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h14
         |-> ##[1:2] (s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0);
   endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("write response missing");
   a_start_with_resp: assert property (p_start_with_resp) else $error("busy without write");
   a_busy_bound: assert property (p_busy_bound) else $error("operation too long");
   a_done_after_busy: assert property (p_done_after_busy) else $error("done pulse missing");
   a_done_pulse: assert property (p_done_pulse) else $error("done pulse too wide");
   a_b_stands: assert property (p_b_stands) else $error("write response dropped");
   a_r_stands: assert property (p_r_stands) else $error("read data dropped");
   a_rd_resp: assert property (p_rd_resp) else $error("read response missing");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read accepted");
endmodule : cpu_bitops_exec_checker

bind cpu_bitops_exec cpu_bitops_exec_checker cpu_bitops_exec_checker_inst (.*);

// ### test/cpu_bitops_exec_bench.sv
// Testbench: register-driven execution of every operation kind
`timescale 1ns/1ps
module cpu_bitops_exec_bench;
   import cpu_bitops_pkg::*;
   logic        clk_sys, rst_n, busy, opDone;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0]  v, e;
   int          mismatches = 0, compares = 0, run = 0, lastRun = 0;
   op_t         atom [4] = '{OP_SWAP_MEMORY_BYTE, OP_LOAD_SET_MEMORY, OP_LOAD_CLEAR_MEMORY, OP_LOAD_TOGGLE_MEMORY};

   cpu_bitops_exec cpu_bitops_exec_inst (.*);

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   // Busy length of the last operation, sampled on the same rising edge of clk_sys that clocks the design
   always @(posedge clk_sys) begin
      if (busy === 1'b1) run <= run + 1;
      else if (run != 0) begin
         lastRun <= run;
         run <= 0;
      end
   end
   // ==========================================
   // Tasks
   task automatic final_report;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : final_report

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check

   task automatic hang(input int n);
      if (n >= 50) begin
         mismatches++;
         $display("MISMATCH t=%0t wait ran out", $time);
         final_report();
      end
   endtask : hang

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
      int  n;
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      n = 0;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
         if (!aw && s_axi_awready === 1'b1) begin
            aw = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w && s_axi_wready === 1'b1) begin
            w = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end while (!(aw && w) && n < 50);
      while (s_axi_bvalid !== 1'b1 && n < 50) begin
         @(posedge clk_sys);
         n++;
      end
      hang(n);
      s_axi_bready <= 1'b0;
      check({30'h0, s_axi_bresp}, {30'h0, r}, "write response");
   endtask : wr

   task automatic rdr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] r = RESP_OKAY);
      int n;
      n = 0;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (s_axi_arready !== 1'b1 && n < 50);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1 && n < 50) begin
         @(posedge clk_sys);
         n++;
      end
      hang(n);
      d = s_axi_rdata;
      s_axi_rready <= 1'b0;
      check({30'h0, s_axi_rresp}, {30'h0, r}, "read response");
   endtask : rdr

   task automatic put(input logic [7:0] a, input logic [7:0] idx, input logic [7:0] val);
      wr(a, {1'b1, 15'h0, idx, val});
   endtask : put

   task automatic get(input logic [7:0] a, input logic [7:0] idx, input logic [7:0] exp, input string what);
      wr(a, {16'h0, idx, 8'h0});
      rdr(a, rd);
      check({24'h0, rd[7:0]}, {24'h0, exp}, what);
   endtask : get

   task automatic stat(input logic [7:0] exp);
      rdr(ADDR_STAT, rd);
      check({23'h0, rd[8:0]}, {24'h0, exp}, "status");
   endtask : stat

   // Launches one operation and checks how many cycles it held busy
   task automatic op(input op_t o, input logic [4:0] r, input logic [2:0] b, input logic [7:0] a, input int cyc);
      int n;
      n = 0;
      wr(ADDR_CMD, {11'h0, cmd_t'{o, r, b, a}});
      while (opDone !== 1'b1 && n < 50) begin
         @(posedge clk_sys);
         n++;
      end
      hang(n);
      @(posedge clk_sys);
      check(lastRun, cyc, "busy cycles");
   endtask : op
   // ==========================================
   // Sequence of tests
   initial begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hf;
      rst_n = 1'b0;
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      stat(STATUS_RESET);
      rdr(ADDR_SP, rd);
      check({24'h0, rd[7:0]}, {24'h0, SP_RESET}, "stack pointer");
      get(ADDR_GPR, 8'h00, GPR_RESET, "register");
      $display("test reset done");
      put(ADDR_IO, 8'h03, 8'ha5);
      wr(ADDR_STAT, 32'h2b);
      op(OP_IO_READ, 5'd1, 3'd0, 8'h03, 1);
      get(ADDR_GPR, 8'h01, 8'ha5, "io read");
      stat(8'h2b);
      op(OP_IO_BIT_SET, 5'd0, 3'd6, 8'h03, 1);
      get(ADDR_IO, 8'h03, 8'he5, "bit set");
      op(OP_IO_BIT_CLEAR, 5'd0, 3'd0, 8'h03, 1);
      get(ADDR_IO, 8'h03, 8'he4, "bit clear");
      stat(8'h2b);
      put(ADDR_GPR, 8'h08, 8'h3c);
      op(OP_IO_WRITE, 5'd8, 3'd0, 8'h07, 1);
      get(ADDR_IO, 8'h07, 8'h3c, "io write");
      op(OP_NOP, 5'd8, 3'd0, 8'h07, 1);
      get(ADDR_IO, 8'h07, 8'h3c, "nop keeps io");
      stat(8'h2b);
      $display("test io done");
      put(ADDR_GPR, 8'h02, 8'h77);
      op(OP_PUSH, 5'd2, 3'd0, 8'h00, 2);
      get(ADDR_MEM, 8'hff, 8'h77, "pushed byte");
      op(OP_POP, 5'd3, 3'd0, 8'h00, 3);
      get(ADDR_GPR, 8'h03, 8'h77, "popped byte");
      rdr(ADDR_SP, rd);
      check({24'h0, rd[7:0]}, 32'h0000_00ff, "stack pointer");
      stat(8'h2b);
      $display("test stack done");
      put(ADDR_GPR, 8'(PTR_REG), 8'h40);
      foreach (atom[i]) begin
         put(ADDR_MEM, 8'h40, 8'hc3);
         put(ADDR_GPR, 8'h04, 8'h5a);
         op(atom[i], 5'd4, 3'd0, 8'h00, 3);
         get(ADDR_GPR, 8'h04, 8'hc3, "old byte");
         e = (i == 0) ? 8'h5a : (i == 1) ? 8'hc3 | 8'h5a : (i == 2) ? 8'hc3 & ~8'h5a : 8'hc3 ^ 8'h5a;
         get(ADDR_MEM, 8'h40, e, "stored byte");
      end
      stat(8'h2b);
      $display("test atomic done");
      wr(ADDR_STAT, 32'h01);
      put(ADDR_GPR, 8'h05, 8'h96);
      op(OP_ROTATE_LEFT_THROUGH_CARRY, 5'd5, 3'd0, 8'h00, 1);
      get(ADDR_GPR, 8'h05, 8'h2d, "rotate left");
      stat(8'h09);
      op(OP_ROTATE_RIGHT_THROUGH_CARRY, 5'd5, 3'd0, 8'h00, 1);
      get(ADDR_GPR, 8'h05, 8'h96, "rotate right");
      stat(8'h05);
      wr(ADDR_STAT, 32'h00);
      put(ADDR_GPR, 8'h06, 8'h08);
      op(OP_BIT_TO_TRANSFER_FLAG, 5'd6, 3'd3, 8'h00, 1);
      stat(8'h40);
      put(ADDR_GPR, 8'h07, 8'h00);
      op(OP_TRANSFER_FLAG_TO_BIT, 5'd7, 3'd5, 8'h00, 1);
      get(ADDR_GPR, 8'h07, 8'h20, "bit load");
      stat(8'h40);
      $display("test rotate and bit done");
      for (int f = 0; f < 8; f++) begin
         v = 8'h01 << f;
         wr(ADDR_STAT, 32'h00);
         op(OP_FLAG_SET, 5'd0, f[2:0], 8'h00, 1);
         stat(v);
         wr(ADDR_STAT, 32'hff);
         op(OP_FLAG_CLEAR, 5'd0, f[2:0], 8'h00, 1);
         stat(~v);
      end
      $display("test flags done");
      rdr(8'h18, rd, RESP_SLVERR);
      check(rd, 32'h0, "unmapped read");
      wr(8'h18, 32'hff, RESP_SLVERR);
      s_axi_wstrb <= 4'h3;
      wr(ADDR_STAT, 32'h00, RESP_SLVERR);
      s_axi_wstrb <= 4'hf;
      stat(8'h7f);
      $display("test refusal done");
      final_report();
   end
endmodule : cpu_bitops_exec_bench
